//--- hib_pkg.sv
`default_nettype none
package hib_pkg;
  // Report layout, byte offsets
  localparam int          REPORT_LEN  = 37;
  localparam int          PAYLOAD_MAX = 32;
  localparam logic [5:0]  OFF_ID      = 6'h00;
  localparam logic [5:0]  OFF_FLAGS   = 6'h01;
  localparam logic [5:0]  OFF_WR      = 6'h02;
  localparam logic [5:0]  OFF_RD      = 6'h03;
  localparam logic [5:0]  OFF_ADDR    = 6'h04;
  localparam logic [5:0]  OFF_DATA    = 6'h05;
  localparam logic [5:0]  OFF_LAST    = 6'h24;
  localparam logic [7:0]  ID_I2C      = 8'h00;
  localparam logic [7:0]  CNT_MAX     = 8'h20;
  // Request flag bit positions
  localparam int          FLG_START   = 0;
  localparam int          FLG_STOP    = 1;
  localparam int          FLG_ACKLAST = 2;
  // Response status bit positions
  localparam int          STS_REQERR  = 0;
  localparam int          STS_NAK     = 1;
  localparam int          STS_ARB     = 2;
  localparam int          STS_TMO     = 3;
  // Timing
  localparam int          CLK_NS      = 20;
  localparam int          BUS_FREE_MS = 256;
  localparam int          BYTE_MS     = 10;
  localparam int          BUS_FREE_CYC = BUS_FREE_MS * 1000000 / CLK_NS;
  localparam int          BYTE_CYC    = BYTE_MS * 1000000 / CLK_NS;
  localparam int          SCL_NS      = 10000;
  localparam int          QTR_CYC     = SCL_NS / CLK_NS / 4;

  typedef enum {BC_START, BC_STOP, BC_WRITE, BC_READ} hib_bcmd_t;
  typedef enum {ST_RECV, ST_CHECK, ST_FREE, ST_START, ST_TX, ST_RX,
                ST_RSTART, ST_STOP, ST_RESP} hib_state_t;
endpackage
`default_nettype wire

//--- hib_i2c_bit.sv
`timescale 1ns/1ns
`default_nettype none
module hib_i2c_bit #(
  parameter int QTR = hib_pkg::QTR_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_cmd_valid,
  input  var  hib_pkg::hib_bcmd_t i_cmd,
  input  wire logic              i_bit,
  input  wire logic              i_abort,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_scl_oe,
  output logic                   o_sda_oe,
  output logic                   o_done,
  output logic                   o_rx,
  output logic                   o_arb
);
  typedef struct packed {
    logic [15:0]        cnt;
    logic [1:0]         ph;
    logic               busy;
    hib_pkg::hib_bcmd_t cmd;
    logic               bit_v;
    logic               scl_oe;
    logic               sda_oe;
    logic               rx;
    logic               done;
    logic               arb;
  } hib_bit_t;

  hib_bit_t q;
  hib_bit_t d;

  // Line levels {scl, sda} per command phase
  function automatic logic [1:0] lv(hib_pkg::hib_bcmd_t c, logic [1:0] p,
                                    logic b);
    logic s;
    s = (p == 2'h1) || (p == 2'h2);
    unique case (c)
      hib_pkg::BC_START: lv = {p[0] ^ p[1], ~p[1]};
      hib_pkg::BC_STOP:  lv = {p != 2'h0, p[1]};
      hib_pkg::BC_WRITE: lv = {s, b};
      hib_pkg::BC_READ:  lv = {s, 1'b1};
    endcase
  endfunction

  always_comb begin
    logic [1:0] l;
    l = lv(q.cmd, q.ph, q.bit_v);
    d = q;
    d.done = 1'b0;
    d.arb = 1'b0;
    if (i_abort) begin
      d.busy = 1'b0;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
    end else if (!q.busy) begin
      if (i_cmd_valid) begin
        d.busy = 1'b1;
        d.cmd = i_cmd;
        d.bit_v = i_bit;
        d.ph = 2'h0;
        d.cnt = '0;
      end
    end else begin
      d.scl_oe = ~l[1];
      d.sda_oe = ~l[0];
      // Hold while a target stretches the clock
      if (!(l[1] && !q.scl_oe && !i_scl))
        d.cnt = q.cnt + 16'h0001;
      if (q.cnt == 16'(QTR - 1)) begin
        d.cnt = '0;
        if (q.ph == 2'h1)
          d.rx = i_sda;
        if (l[0] && l[1] && !i_sda && q.cmd != hib_pkg::BC_READ) begin
          d.arb = 1'b1;
          d.done = 1'b1;
          d.busy = 1'b0;
          d.scl_oe = 1'b0;
          d.sda_oe = 1'b0;
        end else if (q.ph == 2'h3) begin
          d.done = 1'b1;
          d.busy = 1'b0;
        end else begin
          d.ph = q.ph + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_scl_oe = q.scl_oe;
  assign o_sda_oe = q.sda_oe;
  assign o_done = q.done;
  assign o_rx = q.rx;
  assign o_arb = q.arb;
endmodule
`default_nettype wire

//--- hib_bridge.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Identifier zero selects an I2C transfer
// - Request is fixed 37 bytes, fixed layout
// - Every request produces one response report
// - Response carries status, plus read data
// - Flag D0 begins with START
// - Flag D1 ends with STOP
// - Flag D2 acks final read byte
// - Direction bit generated, address D0 ignored
// - Only write-count payload bytes are sent
// - Combined: repeated START, same address, read
// - Full address byte resent after restart, D0 set
// - Response 37 bytes, sequence echoed back
// - Target NAK aborts, status D1 set
// - Lost arbitration aborts, status D2 set
// - Bus-free or byte timeout sets D3
module hib_bridge #(
  parameter int unsigned BUS_FREE_CYC = hib_pkg::BUS_FREE_CYC,
  parameter int unsigned BYTE_CYC     = hib_pkg::BYTE_CYC,
  parameter int          QTR          = hib_pkg::QTR_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_rpt_valid,
  input  wire logic [7:0] i_rpt_data,
  output logic            o_rpt_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data,
  input  wire logic       i_rsp_ready,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  output logic            o_busy
);
  typedef struct packed {
    hib_pkg::hib_state_t st;
    logic [5:0]          idx;
    logic [7:0]          id;
    logic [7:0]          flags;
    logic [7:0]          write_byte_count;
    logic [7:0]          read_byte_count;
    logic [6:0]          target_address_field;
    logic [31:0][7:0]    payload;
    logic [31:0][7:0]    rdata;
    logic [5:0]          widx;
    logic [5:0]          ridx;
    logic [3:0]          bcnt;
    logic                is_addr;
    logic                dir;
    logic [3:0]          status;
    logic [23:0]         tmr;
    logic                pend;
    logic [7:0]          rsp_byte;
  } hib_top_t;

  hib_top_t           q;
  hib_top_t           d;
  logic               cmd_valid;
  hib_pkg::hib_bcmd_t cmd;
  logic               cmd_bit;
  logic               tmo;
  logic               b_done;
  logic               b_rx;
  logic               b_arb;
  logic [7:0]         tx_byte;
  logic               last_rd;

  // Step after a written byte
  function automatic hib_pkg::hib_state_t after_write(logic [5:0] w,
                                                      hib_top_t s);
    if ({2'b00, w} < s.write_byte_count)
      after_write = hib_pkg::ST_TX;
    else if (s.read_byte_count != 8'h00)
      after_write = hib_pkg::ST_RSTART;
    else
      after_write = finish(s);
  endfunction

  // Close with or without STOP
  function automatic hib_pkg::hib_state_t finish(hib_top_t s);
    finish = s.flags[hib_pkg::FLG_STOP] ? hib_pkg::ST_STOP
                                        : hib_pkg::ST_RESP;
  endfunction

  // Response byte at position i
  function automatic logic [7:0] rsp_at(hib_top_t s, logic [5:0] i);
    logic [5:0] k;
    k = i - hib_pkg::OFF_DATA;
    unique case (i)
      hib_pkg::OFF_ID:    rsp_at = hib_pkg::ID_I2C;
      hib_pkg::OFF_FLAGS: rsp_at = {s.flags[7:4], s.status};
      hib_pkg::OFF_WR:    rsp_at = {2'b00, s.widx};
      hib_pkg::OFF_RD:    rsp_at = {2'b00, s.ridx};
      hib_pkg::OFF_ADDR:  rsp_at = 8'h00;
      default:            rsp_at = s.rdata[k[4:0]];
    endcase
  endfunction

  assign tx_byte = q.is_addr ? {q.target_address_field, q.dir}
                             : q.payload[q.widx[4:0]];
  assign last_rd = ({2'b00, q.ridx} + 8'h01) == q.read_byte_count;
  assign tmo = (q.st == hib_pkg::ST_FREE && q.tmr >= 24'(BUS_FREE_CYC))
            || ((q.st == hib_pkg::ST_TX || q.st == hib_pkg::ST_RX)
                && q.tmr >= 24'(BYTE_CYC));

  always_comb begin
    cmd = hib_pkg::BC_WRITE;
    cmd_bit = 1'b1;
    unique case (q.st)
      hib_pkg::ST_START,
      hib_pkg::ST_RSTART: cmd = hib_pkg::BC_START;
      hib_pkg::ST_STOP:   cmd = hib_pkg::BC_STOP;
      hib_pkg::ST_TX: begin
        cmd = q.bcnt[3] ? hib_pkg::BC_READ : hib_pkg::BC_WRITE;
        cmd_bit = tx_byte[~q.bcnt[2:0]];
      end
      hib_pkg::ST_RX: begin
        cmd = q.bcnt[3] ? hib_pkg::BC_WRITE : hib_pkg::BC_READ;
        cmd_bit = last_rd && !q.flags[hib_pkg::FLG_ACKLAST];
      end
      default: cmd = hib_pkg::BC_WRITE;
    endcase
  end

  assign cmd_valid = !q.pend && !tmo &&
                     (q.st == hib_pkg::ST_START || q.st == hib_pkg::ST_TX ||
                      q.st == hib_pkg::ST_RX || q.st == hib_pkg::ST_RSTART ||
                      q.st == hib_pkg::ST_STOP);

  always_comb begin
    d = q;
    d.tmr = q.tmr + 24'h000001;
    if (cmd_valid)
      d.pend = 1'b1;
    if (b_done)
      d.pend = 1'b0;
    unique case (q.st)
      hib_pkg::ST_RECV: begin
        if (i_rpt_valid) begin
          d.idx = q.idx + 6'h01;
          unique case (q.idx)
            hib_pkg::OFF_ID: begin
              d.id = i_rpt_data;
              d.rdata = '0;
            end
            hib_pkg::OFF_FLAGS: d.flags = i_rpt_data;
            hib_pkg::OFF_WR:    d.write_byte_count = i_rpt_data;
            hib_pkg::OFF_RD:    d.read_byte_count = i_rpt_data;
            hib_pkg::OFF_ADDR:  d.target_address_field = i_rpt_data[7:1];
            default: d.payload[5'(q.idx - hib_pkg::OFF_DATA)] = i_rpt_data;
          endcase
          if (q.idx == hib_pkg::OFF_LAST) begin
            d.idx = '0;
            d.st = hib_pkg::ST_CHECK;
          end
        end
      end
      hib_pkg::ST_CHECK: begin
        d.widx = '0;
        d.ridx = '0;
        d.bcnt = '0;
        d.status = '0;
        d.tmr = '0;
        d.is_addr = 1'b0;
        if (q.id != hib_pkg::ID_I2C || q.write_byte_count > hib_pkg::CNT_MAX
            || q.read_byte_count > hib_pkg::CNT_MAX) begin
          d.status[hib_pkg::STS_REQERR] = 1'b1;
          d.st = hib_pkg::ST_RESP;
        end else if (q.flags[hib_pkg::FLG_START]) begin
          d.st = hib_pkg::ST_FREE;
        end else if (q.write_byte_count != 8'h00) begin
          d.st = hib_pkg::ST_TX;
        end else if (q.read_byte_count != 8'h00) begin
          d.st = hib_pkg::ST_RX;
        end else begin
          d.st = finish(q);
        end
      end
      hib_pkg::ST_FREE: begin
        if (i_scl && i_sda)
          d.st = hib_pkg::ST_START;
      end
      hib_pkg::ST_START,
      hib_pkg::ST_RSTART: begin
        if (b_done) begin
          d.is_addr = 1'b1;
          d.dir = (q.st == hib_pkg::ST_RSTART) ||
                  (q.write_byte_count == 8'h00 &&
                   q.read_byte_count != 8'h00);
          d.bcnt = '0;
          d.tmr = '0;
          d.st = hib_pkg::ST_TX;
        end
      end
      hib_pkg::ST_TX: begin
        if (b_done && !q.bcnt[3]) begin
          d.bcnt = q.bcnt + 4'h1;
        end else if (b_done) begin
          d.bcnt = '0;
          d.tmr = '0;
          d.is_addr = 1'b0;
          if (b_rx) begin
            d.status[hib_pkg::STS_NAK] = 1'b1;
            d.st = hib_pkg::ST_STOP;
          end else if (q.is_addr && q.dir) begin
            d.st = (q.read_byte_count != 8'h00) ? hib_pkg::ST_RX
                                                : finish(q);
          end else if (q.is_addr) begin
            d.st = after_write(q.widx, q);
          end else begin
            d.widx = q.widx + 6'h01;
            d.st = after_write(q.widx + 6'h01, q);
          end
        end
      end
      hib_pkg::ST_RX: begin
        if (b_done && !q.bcnt[3]) begin
          d.rdata[q.ridx[4:0]][~q.bcnt[2:0]] = b_rx;
          d.bcnt = q.bcnt + 4'h1;
        end else if (b_done) begin
          d.bcnt = '0;
          d.tmr = '0;
          d.ridx = q.ridx + 6'h01;
          if (last_rd)
            d.st = finish(q);
        end
      end
      hib_pkg::ST_STOP: begin
        if (b_done)
          d.st = hib_pkg::ST_RESP;
      end
      hib_pkg::ST_RESP: begin
        if (i_rsp_ready) begin
          d.idx = q.idx + 6'h01;
          d.rsp_byte = rsp_at(q, q.idx + 6'h01);
          if (q.idx == hib_pkg::OFF_LAST) begin
            d.idx = '0;
            d.st = hib_pkg::ST_RECV;
          end
        end
      end
    endcase
    if (b_done && b_arb) begin
      d.status[hib_pkg::STS_ARB] = 1'b1;
      d.st = hib_pkg::ST_RESP;
    end
    if (tmo) begin
      d.status[hib_pkg::STS_TMO] = 1'b1;
      d.pend = 1'b0;
      d.st = hib_pkg::ST_RESP;
    end
    if (d.st == hib_pkg::ST_RESP && q.st != hib_pkg::ST_RESP) begin
      d.idx = '0;
      d.rsp_byte = hib_pkg::ID_I2C;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n)
      q <= '0;
    else
      q <= d;
  end

  hib_i2c_bit #(
    .QTR (QTR)
  ) u_bit (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_cmd_valid (cmd_valid),
    .i_cmd       (cmd),
    .i_bit       (cmd_bit),
    .i_abort     (tmo),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .o_scl_oe    (o_scl_oe),
    .o_sda_oe    (o_sda_oe),
    .o_done      (b_done),
    .o_rx        (b_rx),
    .o_arb       (b_arb)
  );

  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_rpt_ready = (q.st == hib_pkg::ST_RECV);
  assign o_rsp_valid = (q.st == hib_pkg::ST_RESP);
  assign o_rsp_data = q.rsp_byte;
  assign o_busy = (q.st != hib_pkg::ST_RECV);
endmodule
`default_nettype wire

//--- hib_bridge_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module hib_bridge_asserts (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_rpt_valid,
  input wire logic [7:0] i_rpt_data,
  input wire logic       o_rpt_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_data,
  input wire logic       i_rsp_ready,
  input wire logic       o_busy
);
  typedef struct packed {
    logic [5:0] rq;
    logic [5:0] rc;
    logic [7:0] flg;
    logic [7:0] rdn;
  } hib_chk_t;
  hib_chk_t s_q;
  hib_chk_t s_d;
  logic     rx;
  logic     tx;
  assign rx = i_rpt_valid & o_rpt_ready;
  assign tx = o_rsp_valid & i_rsp_ready;
  // Byte counters and captured fields
  always_comb begin
    s_d = s_q;
    if (rx)
      s_d.rq = (s_q.rq == 6'h24) ? 6'h00 : s_q.rq + 6'h01;
    if (rx && s_q.rq == 6'h01)
      s_d.flg = i_rpt_data;
    if (tx)
      s_d.rc = s_q.rc + 6'h01;
    else if (!o_rsp_valid)
      s_d.rc = 6'h00;
    if (tx && s_q.rc == 6'h03)
      s_d.rdn = o_rsp_data;
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req_last;
    rx && s_q.rq == 6'h24;
  endsequence
  sequence s_rsp_wait;
    o_rsp_valid && !i_rsp_ready;
  endsequence
  a_busy_block: assert property (o_busy |-> !o_rpt_ready)
    else $error("request intake open while busy");
  a_req_length: assert property (s_req_last |=> !o_rpt_ready)
    else $error("intake still open after last byte");
  a_req_early: assert property (
    rx && s_q.rq != 6'h24 |=> o_rpt_ready)
    else $error("intake closed before last byte");
  a_rsp_hold: assert property (
    s_rsp_wait |=> o_rsp_valid && $stable(o_rsp_data))
    else $error("response byte dropped before taken");
  a_rsp_length: assert property (
    $fell(o_rsp_valid) |-> s_q.rc == 6'h25)
    else $error("response length wrong");
  a_rsv_zero: assert property (
    o_rsp_valid && (s_q.rc == 6'h00 || s_q.rc == 6'h04)
    |-> o_rsp_data == 8'h00)
    else $error("identifier or reserved byte not zero");
  a_seq_echo: assert property (
    o_rsp_valid && s_q.rc == 6'h01 |-> o_rsp_data[7:4] == s_q.flg[7:4])
    else $error("sequence number not echoed");
  a_pad_zero: assert property (
    o_rsp_valid && s_q.rc > 6'h04 && {2'b00, s_q.rc} >= s_q.rdn + 8'h05
    |-> o_rsp_data == 8'h00)
    else $error("data beyond read count not zero");
endmodule
bind hib_bridge hib_bridge_asserts u_asserts (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rpt_valid(i_rpt_valid),
  .i_rpt_data(i_rpt_data), .o_rpt_ready(o_rpt_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
  .i_rsp_ready(i_rsp_ready), .o_busy(o_busy));
`default_nettype wire

//--- hib_i2c_target.sv
`timescale 1ns/1ns
`default_nettype none
module hib_i2c_target #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [6:0] ALT  = 7'h78
) (
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  input  wire logic  i_nak,
  output logic       o_sda_oe,
  output logic       o_mack,
  output logic [7:0] o_nwr
);
  int         cnt;
  logic [7:0] sr;
  logic [7:0] dat;
  logic [7:0] n;
  logic       first;
  logic       sel;
  logic       rd;
  logic       tx;
  initial begin
    cnt = 0;
    sel = 1'b0;
    tx = 1'b0;
    first = 1'b0;
    o_sda_oe = 1'b0;
    o_mack = 1'b0;
    o_nwr = 8'h00;
  end
  // Start condition
  always @(negedge i_sda) begin
    if (i_scl) begin
      cnt = 0;
      first = 1'b1;
      tx = 1'b0;
    end
  end
  // Stop condition
  always @(posedge i_sda) begin
    if (i_scl) begin
      sel = 1'b0;
      tx = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (cnt == 8)
      o_mack = ~i_sda;
    else
      sr = {sr[6:0], i_sda};
    cnt = cnt + 1;
  end
  always @(negedge i_scl) begin
    if (cnt == 8 && first) begin
      sel = (sr[7:1] == ADDR || sr[7:1] == ALT) && !i_nak;
      rd = sr[0];
      first = 1'b0;
      n = 8'h00;
      o_sda_oe = sel;
    end else if (cnt == 8) begin
      o_sda_oe = sel && !rd && !i_nak;
      if (o_sda_oe)
        o_nwr = o_nwr + 8'h01;
    end else if (cnt == 9) begin
      cnt = 0;
      tx = sel && rd && o_mack;
      dat = 8'hA0 + n;
      n = n + 8'h01;
      o_sda_oe = tx && !dat[7];
    end else if (tx && cnt > 0) begin
      o_sda_oe = !dat[7 - cnt];
    end
  end
endmodule
`default_nettype wire

//--- hib_bridge_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module hib_bridge_tb_top;
  typedef struct packed {
    logic [7:0] id, flg, wr, rd, adr;
    logic       nak;
    logic [1:0] env;
    logic [3:0] sts;
    logic [7:0] wn, rn;
  } hib_row_t;
  localparam hib_row_t ROWS [10] = '{
    '{8'h00, 8'h13, 8'h02, 8'h00, 8'hA1, 1'b0, 2'h0, 4'h0, 8'h02, 8'h00},
    '{8'h00, 8'h27, 8'h01, 8'h03, 8'hA0, 1'b0, 2'h0, 4'h0, 8'h01, 8'h03},
    '{8'h00, 8'h33, 8'h00, 8'h20, 8'hA0, 1'b0, 2'h0, 4'h0, 8'h00, 8'h20},
    '{8'h00, 8'h43, 8'h20, 8'h00, 8'hA0, 1'b0, 2'h0, 4'h0, 8'h20, 8'h00},
    '{8'h00, 8'h53, 8'h01, 8'h02, 8'hF0, 1'b0, 2'h0, 4'h0, 8'h01, 8'h02},
    '{8'h00, 8'h63, 8'h02, 8'h00, 8'hA0, 1'b1, 2'h0, 4'h2, 8'h00, 8'h00},
    '{8'h01, 8'h73, 8'h01, 8'h00, 8'hA0, 1'b0, 2'h0, 4'h1, 8'h00, 8'h00},
    '{8'h00, 8'h83, 8'h21, 8'h00, 8'hA0, 1'b0, 2'h0, 4'h1, 8'h00, 8'h00},
    '{8'h00, 8'h93, 8'h00, 8'h21, 8'hA0, 1'b0, 2'h0, 4'h1, 8'h00, 8'h00},
    '{8'h00, 8'hA3, 8'h00, 8'h00, 8'hA0, 1'b0, 2'h0, 4'h0, 8'h00, 8'h00}
  };
  logic       clk, reset_n, rpt_valid, rsp_ready, other_scl, other_sda;
  logic       nak, rpt_ready, rsp_valid, scl_oe, sda_oe, busy, tgt_oe, mack;
  logic [7:0] rpt_data, rsp_data, nwr;
  logic [7:0] rsp [37];
  wire logic  scl;
  wire logic  sda;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cycles = 0;
  assign scl = ~(scl_oe | other_scl);
  assign sda = ~(sda_oe | tgt_oe | other_sda);
  always #10 clk = ~clk;
  hib_bridge #(.BUS_FREE_CYC(2000), .BYTE_CYC(400), .QTR(4)) dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_rpt_valid(rpt_valid),
    .i_rpt_data(rpt_data), .o_rpt_ready(rpt_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .i_rsp_ready(rsp_ready), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .o_busy(busy));
  hib_i2c_target #(.ADDR(7'h50), .ALT(7'h78)) tgt (
    .i_scl(scl), .i_sda(sda), .i_nak(nak), .o_sda_oe(tgt_oe),
    .o_mack(mack), .o_nwr(nwr));
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send_req(input hib_row_t r);
    for (int k = 0; k < 37; k++) begin
      @(negedge clk);
      rpt_valid = 1'b1;
      case (k)
        0: rpt_data = r.id;
        1: rpt_data = r.flg;
        2: rpt_data = r.wr;
        3: rpt_data = r.rd;
        4: rpt_data = r.adr;
        default: rpt_data = 8'h0B + 8'(k);
      endcase
      do @(posedge clk); while (rpt_ready !== 1'b1);
    end
    @(negedge clk);
    rpt_valid = 1'b0;
  endtask
  task automatic get_rsp();
    for (int k = 0; k < 37; k++) begin
      @(negedge clk);
      rsp_ready = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge clk);
      rsp[k] = rsp_data;
      rsp_ready = 1'b1;
      @(posedge clk);
    end
    @(negedge clk);
    rsp_ready = 1'b0;
  endtask
  task automatic run_row(input hib_row_t r);
    logic [7:0] nw0;
    nw0 = nwr;
    nak = r.nak;
    other_scl = r.env[0];
    send_req(r);
    if (r.env[1]) begin
      while (scl_oe !== 1'b1) @(negedge clk);
      other_sda = 1'b1;
    end
    get_rsp();
    other_sda = 1'b0;
    other_scl = 1'b0;
    check8(rsp[1], {r.flg[7:4], r.sts});
    check8(rsp[2], r.wn);
    check8(rsp[3], r.rn);
    for (int k = 0; k < 32; k++)
      check8(rsp[k + 5], (k < r.rn) ? 8'hA0 + 8'(k) : 8'h00);
    check8(nwr - nw0, r.wn);
    if (r.rn != 8'h00)
      check8({7'h00, mack}, {7'h00, r.flg[2]});
    $display("test with flags %h done", r.flg);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      $display("mismatch at %0t: run did not finish", $time);
      results();
    end
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    rpt_valid = 1'b0;
    rpt_data = 8'h00;
    rsp_ready = 1'b0;
    other_scl = 1'b0;
    other_sda = 1'b0;
    nak = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    check8({3'h0, rpt_ready, rsp_valid, busy, scl_oe, sda_oe}, 8'h10);
    $display("reset test done");
    for (int i = 0; i < 10; i++)
      run_row(ROWS[i]);
    run_row('{8'h00, 8'hB3, 8'h01, 8'h00, 8'hA0, 1'b0, 2'h2, 4'h4, 8'h00, 8'h00});
    run_row('{8'h00, 8'hC3, 8'h01, 8'h00, 8'hA0, 1'b0, 2'h1, 4'h8, 8'h00, 8'h00});
    results();
  end
endmodule
`default_nettype wire
